// [enrc_region_ctrl.sv]
// External SRAM/PSRAM/NOR region controller with its two configuration registers
// Summary of operation
// - Page size field splits bursts at 128 to 1024 byte pages, or automatically.
// - Asynchronous wait enable makes the wait input stretch asynchronous data phases.
// - Access mode field applies only while extended mode is enabled.
// - Access mode encodings 00 to 11 select waveforms A to D.
// - Burst flash accesses insert wait states only when wait signal is enabled.
// - With write enable clear, writes are refused with an error; set after reset.
// - Wait timing bit: wait one data cycle early, or during the wait state.
// - Wrap enable permits wrapping bursts; otherwise wrapping bursts are not continued.
// - Wait polarity bit selects active low (0) or active high (1) wait.
// - Synchronous burst bit enables burst accesses to the memory.
// - Flash access enable gates flash-specific burst behaviour.
// - Bus width 00 gives 8-bit, 01 gives 16-bit data bus, 16-bit after reset.
// - Memory type selects SRAM, PSRAM or flash, flash after reset.
// - Multiplex bit shares address and data on the data pins.
// - Region enable clear means the bank is never accessed.
// - Synchronous first data comes after latency field plus two memory clocks.
// - Memory clock period is divide field plus one core clocks, zero reserved.
// - After a multiplexed read, wait turnaround field plus one core clocks.
// - Asynchronous data setup lasts field plus one core clocks, zero reserved.
// - Address hold only in mode D or multiplexed, field plus one clocks.
// - Asynchronous address setup lasts field plus one core clocks.
`timescale 1ns/1ps
`default_nettype none
module enrc_region_ctrl
  import enrc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // AHB slave, register space and memory region selects
  input  wire logic        hselReg,
  input  wire logic        hselMem,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic [2:0]  hburst,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // External memory pins
  output logic [25:0]      memAddr,
  output logic [15:0]      memDataOut,
  output logic             memDataOe,
  input  wire logic [15:0] memDataIn,
  output logic             memChipSelN,
  output logic             memOutEnN,
  output logic             memWrEnN,
  output logic             memAddrValidN,
  output logic             mem_clock_out,
  input  wire logic        mem_wait_input
);

  // ==========================================================================
  // Lane select for writes
  function automatic logic [15:0] laneData(input logic [31:0] d, input logic [1:0] a, input logic w8);
    logic [15:0] r;
    r = w8 ? {8'h00, d[{a, 3'h0} +: 8]} : d[{a[1], 4'h0} +: 16];
    return r;
  endfunction

  // Same PSRAM page; automatic and reserved codes never split here
  function automatic logic samePage(input logic [25:0] a, input logic [25:0] b, input logic [2:0] ps);
    logic r;
    r = 1'b1;
    if (ps != PAGE_AUTO && ps <= PAGE_1024)
      r = (a >> (PAGE_SHIFT + int'(ps))) == (b >> (PAGE_SHIFT + int'(ps)));
    return r;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [15:0] dinMeta;
  logic [15:0] dinSync;
  logic        waitMeta;
  logic        waitSync;
  logic        waitPrevHit;
  logic        next_waitPrevHit;
  logic        waitHit;

  // ==========================================================================
  // Configuration registers
  logic [31:0] ctlReg;
  logic [31:0] next_ctlReg;
  logic [31:0] timReg;
  logic [31:0] next_timReg;

  // Field views
  logic       syncWriteSel;
  logic [2:0] pageSize;
  logic       asyncWaitEn;
  logic       extModeEn;
  logic       waitSignalEn;
  logic       writeEn;
  logic       waitTiming;
  logic       wrap_burst_enable;
  logic       waitPol;
  logic       syncBurstEn;
  logic       flashEn;
  logic       width8;
  logic [1:0] memType;
  logic       muxEn;
  logic       regionEn;
  enrc_mode_e effMode;
  assign syncWriteSel = ctlReg[SYNC_WRITE_SELECT_BIT];
  assign pageSize     = ctlReg[PAGE_SIZE_LSB +: 3];
  assign asyncWaitEn  = ctlReg[ASYNC_WAIT_BIT];
  assign extModeEn    = ctlReg[EXT_MODE_BIT];
  assign waitSignalEn = ctlReg[WAIT_SIGNAL_BIT];
  assign writeEn      = ctlReg[WRITE_ENABLE_BIT];
  assign waitTiming   = ctlReg[WAIT_TIMING_BIT];
  assign wrap_burst_enable       = ctlReg[WRAP_BURST_BIT];
  assign waitPol      = ctlReg[WAIT_POLARITY_BIT];
  assign syncBurstEn  = ctlReg[SYNC_BURST_BIT];
  assign flashEn      = ctlReg[FLASH_ACCESS_BIT];
  assign width8       = ctlReg[BUS_WIDTH_LSB +: 2] == WIDTH_8;
  assign memType      = ctlReg[MEM_TYPE_LSB +: 2];
  assign muxEn        = ctlReg[MUX_ENABLE_BIT];
  assign regionEn     = ctlReg[REGION_ENABLE_BIT];
  // Outside extended mode every asynchronous access uses waveform A
  assign effMode = extModeEn ? enrc_mode_e'(timReg[ASYNC_MODE_LSB +: 2]) : ENRC_MODE_A;

  // ==========================================================================
  // Sequencer state
  enrc_state_e state;
  enrc_state_e next_state;
  logic        reqWrite;
  logic        next_reqWrite;
  logic [7:0]  reqOfs;
  logic [7:0]  next_reqOfs;
  logic [25:0] reqAddr;
  logic [25:0] next_reqAddr;
  logic        reqSync;
  logic        next_reqSync;
  logic        burstOpen;
  logic        next_burstOpen;
  logic        grab;
  logic        next_grab;
  logic [15:0] wrData;
  logic [15:0] next_wrData;
  logic        clkRun;
  logic        next_clkRun;
  logic        next_hreadyout;
  logic        next_hresp;
  logic [31:0] next_hrdata;
  logic [25:0] next_memAddr;
  logic [15:0] next_memDataOut;
  logic        next_memDataOe;
  logic        next_memChipSelN;
  logic        next_memOutEnN;
  logic        next_memWrEnN;
  logic        next_memAddrValidN;
  logic        accept;
  logic        syncSel;
  logic        contBurst;
  logic        asyncStall;
  logic        syncStall;
  logic        needHold;
  logic        addrPhase;
  logic        dataPhase;
  logic [31:0] readWord;

  enrc_timer_if tif ();

  enrc_phase_timer timer_i (
    .core_clk (core_clk),
    .rst      (rst),
    .tif      (tif)
  );

  // Wait line conditioning
  always_comb
  begin
    waitHit = waitPol ? waitSync : !waitSync;
    next_waitPrevHit = tif.clkRise ? waitHit : waitPrevHit;
    asyncStall = asyncWaitEn && waitHit;
    // Early-wait mode acts on the level seen one data cycle before
    syncStall = waitSignalEn && (waitTiming ? waitHit : waitPrevHit);
    needHold = (effMode == ENRC_MODE_D) || muxEn;
    readWord = width8 ? {4{dinSync[7:0]}} : {2{dinSync}};
  end

  // Two-stage synchronisers for the asynchronous pins
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dinMeta     <= 16'h0000;
      dinSync     <= 16'h0000;
      waitMeta    <= 1'b0;
      waitSync    <= 1'b0;
      waitPrevHit <= 1'b0;
    end
    else
    begin
      dinMeta     <= memDataIn;
      dinSync     <= dinMeta;
      waitMeta    <= mem_wait_input;
      waitSync    <= waitMeta;
      waitPrevHit <= next_waitPrevHit;
    end
  end

  // Register writes land in the data phase; reserved bits are kept fixed
  always_comb
  begin
    next_ctlReg = ctlReg;
    next_timReg = timReg;
    if (state == ST_REG_WR)
    begin
      if (reqOfs == CTL_OFS)
        next_ctlReg = (hwdata & CTL_WMASK) | CTL_FIXED;
      else if (reqOfs == TIM_OFS)
        next_timReg = hwdata & TIM_WMASK;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctlReg <= CTL_RST;
      timReg <= TIM_RST;
    end
    else
    begin
      ctlReg <= next_ctlReg;
      timReg <= next_timReg;
    end
  end

  // Access sequencer and registered pin values
  always_comb
  begin
    next_state     = state;
    next_reqWrite  = reqWrite;
    next_reqOfs    = reqOfs;
    next_reqAddr   = reqAddr;
    next_reqSync   = reqSync;
    next_burstOpen = burstOpen;
    next_grab      = 1'b0;
    next_wrData    = grab ? laneData(hwdata, reqAddr[1:0], width8) : wrData;
    next_hrdata    = hrdata;
    accept = (state == ST_IDLE || state == ST_REG_WR || state == ST_ERR2) && hready && htrans[1]
             && (hselReg || hselMem);
    // Flash bursts need the flash access enable
    syncSel = (hwrite ? syncWriteSel : 1'b1) && syncBurstEn
              && (memType != MEM_FLASH || flashEn);
    contBurst = burstOpen && htrans == HTRANS_SEQ && hwrite == reqWrite
                && samePage(haddr[25:0], reqAddr, pageSize)
                && (wrap_burst_enable || hburst[0] || hburst == 3'h0);
    case (state)
      ST_IDLE, ST_REG_WR, ST_ERR2:
      begin
        next_state = ST_IDLE;
        next_burstOpen = 1'b0;
        if (accept)
        begin
          next_reqWrite = hwrite;
          next_reqOfs   = haddr[7:0];
          next_reqAddr  = haddr[25:0];
          next_reqSync  = syncSel;
          if (hselReg)
          begin
            if (hwrite)
              next_state = ST_REG_WR;
            else
              next_hrdata = (haddr[7:0] == CTL_OFS) ? ctlReg : (haddr[7:0] == TIM_OFS) ? timReg : 32'h0;
          end
          else if (!regionEn || (hwrite && !writeEn))
            next_state = ST_ERR1;
          else
          begin
            next_grab = hwrite;
            if (contBurst)
            begin
              next_state = ST_SYNC_DATA;
              next_burstOpen = 1'b1;
            end
            else if (burstOpen)
              next_state = ST_CLOSE;
            else
              next_state = syncSel ? ST_SYNC_LAT : ST_ADDR_SETUP;
          end
        end
      end
      ST_ERR1:
        next_state = ST_ERR2;
      ST_CLOSE:
        next_state = reqSync ? ST_SYNC_LAT : ST_ADDR_SETUP;
      ST_ADDR_SETUP:
        if (tif.done)
          next_state = needHold ? ST_ADDR_HOLD : ST_DATA_SETUP;
      ST_ADDR_HOLD:
        if (tif.done)
          next_state = ST_DATA_SETUP;
      ST_DATA_SETUP:
        if (tif.done && !asyncStall)
        begin
          next_hrdata = readWord;
          next_state = (!reqWrite && muxEn) ? ST_TURN : ST_IDLE;
        end
      ST_SYNC_LAT:
        if (tif.done)
          next_state = ST_SYNC_DATA;
      ST_SYNC_DATA:
        if (tif.clkRise && !syncStall)
        begin
          next_hrdata = readWord;
          next_state = ST_IDLE;
          next_burstOpen = 1'b1;
        end
      ST_TURN:
        if (tif.done)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase

    next_clkRun    = next_state == ST_SYNC_LAT || next_state == ST_SYNC_DATA || next_burstOpen;
    next_hreadyout = next_state == ST_IDLE || next_state == ST_REG_WR || next_state == ST_ERR2;
    next_hresp     = next_state == ST_ERR1 || next_state == ST_ERR2;
    addrPhase = next_state == ST_ADDR_SETUP || next_state == ST_ADDR_HOLD || next_state == ST_SYNC_LAT;
    dataPhase = next_state == ST_DATA_SETUP || next_state == ST_SYNC_DATA;
    next_memAddr = width8 ? next_reqAddr : {1'b0, next_reqAddr[25:1]};
    // Shared pins carry the address first, then the data
    next_memDataOut = (muxEn && addrPhase) ? next_memAddr[15:0] : next_wrData;
    next_memDataOe  = (muxEn && addrPhase) || (next_reqWrite && dataPhase);
    next_memChipSelN = !(addrPhase || dataPhase || next_burstOpen);
    next_memOutEnN   = !(!next_reqWrite && dataPhase);
    next_memWrEnN    = !(next_reqWrite && dataPhase);
    // Waveforms B to D and shared pins pulse address valid during setup
    next_memAddrValidN = !(next_state == ST_SYNC_LAT
                         || (next_state == ST_ADDR_SETUP && (muxEn || effMode != ENRC_MODE_A)));
  end

  // Phase lengths, loaded as the sequencer enters each phase
  always_comb
  begin
    tif.load   = next_state != state;
    tif.onRise = state == ST_SYNC_LAT;
    tif.pause  = state == ST_DATA_SETUP && asyncStall;
    tif.clkRun = clkRun;
    tif.clkDiv = timReg[CLK_DIV_LSB +: 4];
    case (next_state)
      ST_ADDR_SETUP: tif.loadVal = {5'h00, timReg[ADDR_SETUP_LSB +: 4]};
      ST_ADDR_HOLD:  tif.loadVal = (timReg[ADDR_HOLD_LSB +: 4] == 4'h0) ? 9'h001
                                   : {5'h00, timReg[ADDR_HOLD_LSB +: 4]};
      ST_DATA_SETUP: tif.loadVal = (timReg[DATA_SETUP_LSB +: 8] == 8'h00) ? 9'h001
                                   : {1'b0, timReg[DATA_SETUP_LSB +: 8]};
      ST_SYNC_LAT:   tif.loadVal = {5'h00, timReg[LATENCY_LSB +: 4]} + LATENCY_ADD;
      ST_TURN:       tif.loadVal = {5'h00, timReg[TURNAROUND_LSB +: 4]};
      default:       tif.loadVal = 9'h000;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state         <= ST_IDLE;
      reqWrite      <= 1'b0;
      reqOfs        <= 8'h00;
      reqAddr       <= 26'h0000000;
      reqSync       <= 1'b0;
      burstOpen     <= 1'b0;
      grab          <= 1'b0;
      wrData        <= 16'h0000;
      clkRun        <= 1'b0;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      hrdata        <= 32'h00000000;
      memAddr       <= 26'h0000000;
      memDataOut    <= 16'h0000;
      memDataOe     <= 1'b0;
      memChipSelN   <= 1'b1;
      memOutEnN     <= 1'b1;
      memWrEnN      <= 1'b1;
      memAddrValidN <= 1'b1;
    end
    else
    begin
      state         <= next_state;
      reqWrite      <= next_reqWrite;
      reqOfs        <= next_reqOfs;
      reqAddr       <= next_reqAddr;
      reqSync       <= next_reqSync;
      burstOpen     <= next_burstOpen;
      grab          <= next_grab;
      wrData        <= next_wrData;
      clkRun        <= next_clkRun;
      hreadyout     <= next_hreadyout;
      hresp         <= next_hresp;
      hrdata        <= next_hrdata;
      memAddr       <= next_memAddr;
      memDataOut    <= next_memDataOut;
      memDataOe     <= next_memDataOe;
      memChipSelN   <= next_memChipSelN;
      memOutEnN     <= next_memOutEnN;
      memWrEnN      <= next_memWrEnN;
      memAddrValidN <= next_memAddrValidN;
    end
  end

  // Divider flop drives the pin directly
  assign mem_clock_out = tif.clkLevel;

endmodule
`default_nettype wire

// [enrc_pkg.sv]
// Constants, field layout and types of the external memory region controller
package enrc_pkg;

  // ==========================================================================
  // Register offsets and reset values
  localparam logic [7:0]  CTL_OFS   = 8'h00;
  localparam logic [7:0]  TIM_OFS   = 8'h04;
  localparam logic [31:0] CTL_RST   = 32'h000030db;
  localparam logic [31:0] TIM_RST   = 32'h0fffffff;
  localparam logic [31:0] CTL_WMASK = 32'h000fff7f;
  localparam logic [31:0] CTL_FIXED = 32'h00000080;
  localparam logic [31:0] TIM_WMASK = 32'h3fffffff;

  // ==========================================================================
  // Control register fields
  localparam int SYNC_WRITE_SELECT_BIT = 19;
  localparam int PAGE_SIZE_LSB         = 16;
  localparam int ASYNC_WAIT_BIT        = 15;
  localparam int EXT_MODE_BIT          = 14;
  localparam int WAIT_SIGNAL_BIT       = 13;
  localparam int WRITE_ENABLE_BIT      = 12;
  localparam int WAIT_TIMING_BIT       = 11;
  localparam int WRAP_BURST_BIT        = 10;
  localparam int WAIT_POLARITY_BIT     = 9;
  localparam int SYNC_BURST_BIT        = 8;
  localparam int FLASH_ACCESS_BIT      = 6;
  localparam int BUS_WIDTH_LSB         = 4;
  localparam int MEM_TYPE_LSB          = 2;
  localparam int MUX_ENABLE_BIT        = 1;
  localparam int REGION_ENABLE_BIT     = 0;

  // ==========================================================================
  // Timing register fields
  localparam int ASYNC_MODE_LSB  = 28;
  localparam int LATENCY_LSB     = 24;
  localparam int CLK_DIV_LSB     = 20;
  localparam int TURNAROUND_LSB  = 16;
  localparam int DATA_SETUP_LSB  = 8;
  localparam int ADDR_HOLD_LSB   = 4;
  localparam int ADDR_SETUP_LSB  = 0;

  // ==========================================================================
  // Field encodings
  localparam logic [1:0] MEM_SRAM   = 2'h0;
  localparam logic [1:0] MEM_PSRAM  = 2'h1;
  localparam logic [1:0] MEM_FLASH  = 2'h2;
  localparam logic [1:0] WIDTH_8    = 2'h0;
  localparam logic [2:0] PAGE_AUTO  = 3'h0;
  localparam logic [2:0] PAGE_1024  = 3'h4;
  localparam int         PAGE_SHIFT = 6;
  localparam logic [8:0] LATENCY_ADD = 9'h002;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef enum logic [1:0] {ENRC_MODE_A, ENRC_MODE_B, ENRC_MODE_C, ENRC_MODE_D} enrc_mode_e;

  typedef enum logic [3:0] {
    ST_IDLE, ST_REG_WR, ST_ERR1, ST_ERR2, ST_CLOSE, ST_ADDR_SETUP, ST_ADDR_HOLD,
    ST_DATA_SETUP, ST_SYNC_LAT, ST_SYNC_DATA, ST_TURN
  } enrc_state_e;

endpackage

// [enrc_timer_if.sv]
// Link between the access sequencer and the phase timer
`timescale 1ns/1ps
`default_nettype none
interface enrc_timer_if;
  logic       load;
  logic [8:0] loadVal;
  logic       onRise;
  logic       pause;
  logic       clkRun;
  logic [3:0] clkDiv;
  logic       done;
  logic       clkRise;
  logic       clkLevel;
  modport ctrl  (output load, loadVal, onRise, pause, clkRun, clkDiv, input done, clkRise, clkLevel);
  modport timer (input load, loadVal, onRise, pause, clkRun, clkDiv, output done, clkRise, clkLevel);
endinterface
`default_nettype wire

// [enrc_phase_timer.sv]
// Phase counter and memory clock divider
`timescale 1ns/1ps
`default_nettype none
module enrc_phase_timer
  import enrc_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst,
  // Sequencer side
  enrc_timer_if.timer tif
);

  // ==========================================================================
  // Counter and divider
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic [3:0] divCnt;
  logic [3:0] next_divCnt;
  logic [3:0] divEff;
  logic [4:0] half;
  logic       clkLevel;
  logic       next_clkLevel;
  logic       clkRise;
  logic       next_clkRise;
  logic       step;

  // Next counter and divider values, counted in core clocks except the latency phase, which steps on memory clock rises
  always_comb
  begin
    divEff = (tif.clkDiv == 4'h0) ? 4'h1 : tif.clkDiv;
    half = 5'(({1'b0, divEff} + 5'h01) >> 1);
    step = tif.onRise ? clkRise : !tif.pause;
    next_cnt = cnt;
    if (tif.load)
      next_cnt = tif.loadVal;
    else if (cnt != 9'h000 && step)
      next_cnt = cnt - 9'h001;
    // Parked at the top so the first running cycle wraps to a rise
    if (!tif.clkRun)
      next_divCnt = divEff;
    else if (divCnt >= divEff)
      next_divCnt = 4'h0;
    else
      next_divCnt = divCnt + 4'h1;
    next_clkRise = tif.clkRun && next_divCnt == 4'h0;
    next_clkLevel = tif.clkRun && ({1'b0, next_divCnt} < half);
  end

  // Registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt      <= 9'h000;
      divCnt   <= 4'h0;
      clkRise  <= 1'b0;
      clkLevel <= 1'b0;
    end
    else
    begin
      cnt      <= next_cnt;
      divCnt   <= next_divCnt;
      clkRise  <= next_clkRise;
      clkLevel <= next_clkLevel;
    end
  end

  assign tif.done     = (cnt == 9'h000);
  assign tif.clkRise  = clkRise;
  assign tif.clkLevel = clkLevel;

endmodule
`default_nettype wire

// [enrc_region_ctrl_assertions.sv]
// Port-level checker of the external memory region controller
`timescale 1ns/1ps
`default_nettype none
module enrc_region_ctrl_assertions
  import enrc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched outputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic memDataOe,
  input wire logic memChipSelN,
  input wire logic memOutEnN,
  input wire logic memWrEnN,
  input wire logic mem_clock_out
);
  // ==========================================================================
  // Port relations
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_rst_idle;
    disable iff (1'b0) rst |=> hreadyout && !hresp && memChipSelN && !memDataOe && !mem_clock_out;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_err_two;
    $rose(hresp) |-> !hreadyout ##1 (hresp && hreadyout);
  endproperty
  a_err_two: assert property (p_err_two) else $error("error response not two cycles");
  property p_err_quiet;
    hresp |-> memChipSelN && memWrEnN && memOutEnN;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("pin activity on refused access");
  property p_one_strobe;
    !memWrEnN |-> memOutEnN && !memChipSelN;
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("write strobe outside a selected write");
  property p_oe_free;
    !memOutEnN |-> !memDataOe && !memChipSelN;
  endproperty
  a_oe_free: assert property (p_oe_free) else $error("data pins driven during read");
  property p_clk_idle;
    memChipSelN && $past(memChipSelN) |-> !mem_clock_out;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("memory clock runs while idle");
  property p_wait_bound;
    $fell(hreadyout) |-> ##[1:1000] hreadyout;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("access never completes");
  property p_cs_ends;
    $fell(memChipSelN) |-> !hreadyout [*2];
  endproperty
  a_cs_ends: assert property (p_cs_ends) else $error("ready while chip still selected");
endmodule

bind enrc_region_ctrl enrc_region_ctrl_assertions u_chk (.core_clk(core_clk), .rst(rst), .hreadyout(hreadyout),
  .hresp(hresp), .memDataOe(memDataOe), .memChipSelN(memChipSelN), .memOutEnN(memOutEnN),
  .memWrEnN(memWrEnN), .mem_clock_out(mem_clock_out));
`default_nettype wire

// [enrc_mem_model.sv]
// Behavioural asynchronous 16-bit memory on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module enrc_mem_model
(
  // Clock for sampling the strobes
  input  wire logic        core_clk,
  // Memory pins
  input  wire logic [25:0] memAddr,
  input  wire logic [15:0] memDataOut,
  input  wire logic        memChipSelN,
  input  wire logic        memOutEnN,
  input  wire logic        memWrEnN,
  output logic [15:0]      memDataIn,
  output logic             mem_wait_input
);
  logic [15:0] store [256];
  logic [15:0] lastOut = 16'h0;
  int          weAge = 0;
  // Wait pulses low in the second and third write strobe cycles; harmless unless enabled
  assign mem_wait_input = !(weAge == 1 || weAge == 2);
  // Last cycle of the write strobe wins
  always_ff @(posedge core_clk)
  begin
    if (!memChipSelN && !memWrEnN)
      store[memAddr[7:0]] <= memDataOut;
    lastOut <= memDataIn;
    weAge   <= memWrEnN ? 0 : weAge + 1;
  end
  // Released bus toggles so a stale value cannot pass
  assign memDataIn = (!memChipSelN && !memOutEnN) ? store[memAddr[7:0]] : ~lastOut;
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking testbench of the external memory region controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import enrc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hselReg = 1'b0;
  logic        hselMem = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout, hresp, memDataOe, memChipSelN, memOutEnN, memWrEnN, mem_clock_out, mem_wait_input, err;
  logic        memAddrValidN;
  logic [25:0] memAddr;
  logic [15:0] memDataOut, memDataIn;
  int          mismatches = 0;
  int          check_count = 0;
  int          csCnt = 0;
  int          weCnt = 0;
  int          avCnt = 0;

  // ==========================================================================
  // Design, memory and clock
  enrc_region_ctrl u_dut (.core_clk(core_clk), .rst(rst), .hselReg(hselReg), .hselMem(hselMem), .haddr(haddr),
    .htrans(htrans), .hburst(3'h0), .hwrite(hwrite), .hready(1'b1), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .memAddr(memAddr), .memDataOut(memDataOut), .memDataOe(memDataOe),
    .memDataIn(memDataIn), .memChipSelN(memChipSelN), .memOutEnN(memOutEnN), .memWrEnN(memWrEnN),
    .memAddrValidN(memAddrValidN), .mem_clock_out(mem_clock_out), .mem_wait_input(mem_wait_input));
  enrc_mem_model u_mem (.core_clk(core_clk), .memAddr(memAddr), .memDataOut(memDataOut),
    .memChipSelN(memChipSelN), .memOutEnN(memOutEnN), .memWrEnN(memWrEnN), .memDataIn(memDataIn),
    .mem_wait_input(mem_wait_input));
  always #25 core_clk = ~core_clk;
  // Strobe cycle counters, cleared at each request
  always @(posedge core_clk)
  begin
    csCnt += !memChipSelN;
    weCnt += !memWrEnN;
    avCnt += !memAddrValidN;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One AHB transfer; ready is sampled at the falling edge before it is taken
  task automatic xfer(input logic isReg, input logic [31:0] a, input logic wr, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    #1;
    {hselReg, hselMem, htrans, haddr, hwrite} = {isReg, !isReg, 2'h2, a, wr};
    csCnt = 0;
    weCnt = 0;
    avCnt = 0;
    @(posedge core_clk);
    #1;
    {hselReg, hselMem, htrans, hwdata} = {2'b00, 2'h0, wd};
    n = 0;
    do
    begin
      @(negedge core_clk);
      n++;
    end
    while (!hreadyout && n < 2000);
    // A transfer that never completes is a failure, not a silent skip
    if (!hreadyout)
      mismatches++;
    rd = hrdata;
    err = hresp;
  endtask
  task automatic async_len(input logic [31:0] ctl, input int expCs, input int expWe);
    xfer(1'b1, 32'h0, 1'b1, ctl);
    xfer(1'b0, 32'h10, 1'b1, 32'h0000a5c3);
    check(csCnt, expCs);
    check(weCnt, expWe);
    check(err, expWe == 0);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    xfer(1'b1, 32'h0, 1'b0, 32'h0);
    check(rd, 32'h000030db);
    xfer(1'b1, 32'h4, 1'b0, 32'h0);
    check(rd, 32'h0fffffff);
    xfer(1'b1, 32'h8, 1'b0, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_reserved;
    xfer(1'b1, 32'h0, 1'b1, 32'hffffffff);
    xfer(1'b1, 32'h4, 1'b1, 32'hffffffff);
    xfer(1'b1, 32'h0, 1'b0, 32'h0);
    check(rd, 32'h000fffff);
    xfer(1'b1, 32'h4, 1'b0, 32'h0);
    check(rd, 32'h3fffffff);
  endtask
  // Every access mode with extended mode on; only D adds the hold phase
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      xfer(1'b1, 32'h4, 1'b1, {2'h0, m[1:0], 28'h0100312});
      async_len(32'h00005091, (m == 3) ? 9 : 7, 4);
      check(avCnt, (m == 0) ? 0 : 3);
    end
  endtask
  task automatic t_ext_mux;
    async_len(32'h00001091, 7, 4);
    async_len(32'h00009091, 9, 6);
    xfer(1'b1, 32'h4, 1'b1, 32'h00100312);
    async_len(32'h00001093, 9, 4);
    xfer(1'b0, 32'h10, 1'b0, 32'h0);
    check(rd, 32'ha5c3a5c3);
  endtask
  task automatic t_refuse;
    async_len(32'h00000091, 0, 0);
    xfer(1'b0, 32'h10, 1'b0, 32'h0);
    check(err, 1'b0);
    xfer(1'b1, 32'h0, 1'b1, 32'h00001090);
    xfer(1'b0, 32'h10, 1'b0, 32'h0);
    check({err, 31'(csCnt)}, 32'h80000000);
  endtask

  // ==========================================================================
  // Verdict, main sequence and watchdog
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_reserved();
    t_modes();
    t_ext_mux();
    t_refuse();
    summarize();
  end
  // Whole run needs under 150 cycles; allow far more
  initial
  begin
    #(20000 * 50);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
